// [rfh_pkg.sv]
// Constants, types and register map of the regulator fault and hiccup sequencer
package rfh_pkg;
    localparam int CLK_NS = 50;
    localparam int LEB_NS = 150;
    localparam int LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int OK_DELAY_NS = 5000000;
    localparam int OK_DELAY_CYC = OK_DELAY_NS / CLK_NS;
    localparam int CNT_W = 7;
    localparam int OCP_LIM_LOW = 30;
    localparam int OCP_LIM_HIGH = 120;
    localparam int BOOT_MISS_CYC = 14;
    localparam int BOOT_SHORT_CYC = 32;
    localparam int FB_W = 8;
    localparam int FB_FULL = 255;
    localparam int FREQ_W = 12;
    localparam int MIN_PCT = 12;
    localparam int FULL_PCT = 100;
    localparam int FREQ_FLOOR_KHZ = 100;
    localparam logic [FREQ_W-1:0] BASE_FREQ_RST = 12'h190;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BASE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CNT = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    // Positions of the comparator flags in the flag vector
    localparam int FL_EN = 0;
    localparam int FL_SS_OFF = 1;
    localparam int FL_SS_REF = 2;
    localparam int FL_SS_CLR = 3;
    localparam int FL_SS_HLOW = 4;
    localparam int FL_SS_FB = 5;
    localparam int FL_FB_REG = 6;
    localparam int FL_FB_OV = 7;
    localparam int FL_FB_UV = 8;
    localparam int FL_FB_MID = 9;
    localparam int FL_I_HARD = 10;
    localparam int FL_I_BUCK = 11;
    localparam int FL_I_BB = 12;
    localparam int FL_BB_MODE = 13;
    localparam int FL_BOOT_MISS = 14;
    localparam int FL_BOOT_SHORT = 15;
    localparam int FL_TSD = 16;
    localparam int FL_VIN_START = 17;
    localparam int FL_VIN_STOP = 18;
    localparam int FL_PWM_CLK = 19;
    localparam int FL_HS_ON = 20;
    localparam int NFLAG = 21;
    typedef enum logic [2:0] {
        ST_FAULT, ST_CHARGE, ST_RUN, ST_HICCUP, ST_LATCH
    } rfh_state_e;
    typedef struct packed {
        logic pin_ok;
        logic ok_released;
        logic pwm_on;
        logic retry;
        logic vin_ok;
        rfh_state_e state;
    } rfh_stat_s;
    typedef struct packed {
        logic [CNT_W-1:0] boot;
        logic [CNT_W-1:0] overcurrent_protection;
    } rfh_cnt_s;
endpackage

// [rfh_cnt_if.sv]
// Link between the sequencer and a PWM cycle counter
`timescale 1ns/1ps
`default_nettype none
interface rfh_cnt_if #(parameter int W = 7);
    logic tick;
    logic cond;
    logic clr;
    logic [W-1:0] limit;
    logic [W-1:0] count;
    logic reached;
    modport ctl(output tick, output cond, output clr, output limit,
                input count, input reached);
    modport cnt(input tick, input cond, input clr, input limit,
                output count, output reached);
endinterface
`default_nettype wire

// [rfh_sync.sv]
// Two-stage synchroniser for comparator flags
`timescale 1ns/1ps
`default_nettype none
module rfh_sync #(parameter int W = 1) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rfh_sync_s;
    rfh_sync_s s_q;
    rfh_sync_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule // rfh_sync
`default_nettype wire

// [rfh_cycle_counter.sv]
// Counter of consecutive PWM cycles that show a condition
`timescale 1ns/1ps
`default_nettype none
module rfh_cycle_counter #(parameter int W = 7) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    rfh_cnt_if.cnt cif
);
    typedef struct packed {
        logic seen;
        logic [W-1:0] count;
    } rfh_ctr_s;
    rfh_ctr_s c_q;
    rfh_ctr_s c_d;

    always_comb begin
        c_d = c_q;
        if (cif.cond) begin
            c_d.seen = 1'b1;
        end
        if (cif.tick) begin
            c_d.seen = 1'b0;
            if (c_q.seen || cif.cond) begin
                if (c_q.count != '1) begin
                    c_d.count = c_q.count + 1'b1;
                end
            end else begin
                c_d.count = '0;
            end
        end
        if (cif.clr) begin
            c_d = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    assign cif.count = c_q.count;
    assign cif.reached = (c_q.count >= cif.limit);
endmodule // rfh_cycle_counter
`default_nettype wire

// [rfh_sequencer.sv]
// Startup, fault, hiccup and output-ok sequencer with APB registers
`timescale 1ns/1ps
`default_nettype none
module rfh_sequencer
    import rfh_pkg::*;
#(
    parameter int OK_DELAY = rfh_pkg::OK_DELAY_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [rfh_pkg::NFLAG-1:0] flag_in,
    input wire logic [rfh_pkg::FB_W-1:0] fb_level,
    input wire logic ok_ind_i,
    output logic ok_ind_o,
    output logic ok_ind_oe,
    output logic ss_source_en,
    output logic ss_fast_dis,
    output logic ss_slow_sink,
    output logic comp_pull_down,
    output logic pwm_enable,
    output logic hs_force_off,
    output logic target_ref,
    output logic [rfh_pkg::FREQ_W-1:0] freq_khz,
    output logic freq_half,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rfh_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import rfh_pkg::*;

    localparam int OKW = $clog2(OK_DELAY + 1);
    localparam int LBW = $clog2(LEB_CYC + 1);
    localparam int SYW = NFLAG + FB_W + 1;

    typedef struct packed {
        rfh_state_e state;
        logic vin_ok;
        logic retry;
        logic pwm_d;
        logic hs_d;
        logic [LBW-1:0] blank;
        logic [OKW-1:0] okcnt;
        logic ctrl_en;
        logic [FREQ_W-1:0] base;
        logic ss_src;
        logic ss_fast;
        logic ss_slow;
        logic comp_pd;
        logic pwm_en;
        logic hs_off;
        logic tgt_ref;
        logic [FREQ_W-1:0] freq;
        logic half;
        logic ok_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rfh_main_s;

    rfh_main_s s_q;
    rfh_main_s s_d;

    logic [SYW-1:0] syn;
    logic [NFLAG-1:0] f;
    logic [FB_W-1:0] fb_s;
    logic pin_ok_s;
    logic tick;
    logic hs_rise;
    logic fault;
    logic hard;
    logic oc_pulse;
    logic run;
    logic setup;
    rfh_state_e ns;
    rfh_stat_s stat;
    rfh_cnt_s cnts;

    rfh_cnt_if #(.W(CNT_W)) ocp_if();
    rfh_cnt_if #(.W(CNT_W)) boot_if();

    // Comparator flags into the clock domain
    rfh_sync #(.W(SYW)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .d({ok_ind_i, fb_level, flag_in}),
        .q(syn)
    );
    assign f = syn[NFLAG-1:0];
    assign fb_s = syn[NFLAG+FB_W-1:NFLAG];
    assign pin_ok_s = syn[SYW-1];

    rfh_cycle_counter #(.W(CNT_W)) u_ocp_cnt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cif(ocp_if)
    );
    rfh_cycle_counter #(.W(CNT_W)) u_boot_cnt (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .cif(boot_if)
    );

    // Startup frequency from feedback level
    function automatic logic [FREQ_W-1:0] rfh_freq(
        input logic [FREQ_W-1:0] base,
        input logic [FB_W-1:0] fb,
        input logic half
    );
        int fr;
        fr = int'(base) * (MIN_PCT * FB_FULL + (FULL_PCT - MIN_PCT) *
             int'(fb)) / (FULL_PCT * FB_FULL);
        if (half) begin
            fr = fr / 2;
        end
        if (fr < FREQ_FLOOR_KHZ) begin
            fr = FREQ_FLOOR_KHZ;
        end
        return FREQ_W'(fr);
    endfunction

    assign tick = f[FL_PWM_CLK] && !s_q.pwm_d;
    assign hs_rise = f[FL_HS_ON] && !s_q.hs_d;
    assign run = (s_q.state == ST_RUN);
    assign fault = !f[FL_EN] || !s_q.ctrl_en || !s_q.vin_ok ||
                   f[FL_TSD];
    assign hard = run && f[FL_I_HARD] && (s_q.blank == '0);
    assign oc_pulse = (f[FL_BB_MODE] ? f[FL_I_BB] : f[FL_I_BUCK]) &&
                      !f[FL_I_HARD] && (s_q.blank == '0);
    assign setup = psel && !penable;

    assign ocp_if.tick = tick;
    assign ocp_if.cond = run && oc_pulse;
    assign ocp_if.clr = !run;
    assign ocp_if.limit = f[FL_FB_MID] ? CNT_W'(OCP_LIM_HIGH) :
                          CNT_W'(OCP_LIM_LOW);
    assign boot_if.tick = tick;
    assign boot_if.cond = run && (f[FL_BOOT_MISS] || f[FL_BOOT_SHORT]);
    assign boot_if.clr = !run;
    assign boot_if.limit = f[FL_BOOT_SHORT] ? CNT_W'(BOOT_SHORT_CYC) :
                           CNT_W'(BOOT_MISS_CYC);

    always_comb begin
        stat = '0;
        stat.state = s_q.state;
        stat.vin_ok = s_q.vin_ok;
        stat.retry = s_q.retry;
        stat.pwm_on = s_q.pwm_en;
        stat.ok_released = !s_q.ok_oe;
        stat.pin_ok = pin_ok_s;
        cnts.overcurrent_protection = ocp_if.count;
        cnts.boot = boot_if.count;
    end

    always_comb begin
        s_d = s_q;
        ns = s_q.state;
        s_d.pwm_d = f[FL_PWM_CLK];
        s_d.hs_d = f[FL_HS_ON];
        if (hs_rise) begin
            s_d.blank = LBW'(LEB_CYC);
        end else if (s_q.blank != '0) begin
            s_d.blank = s_q.blank - 1'b1;
        end
        if (f[FL_VIN_START]) begin
            s_d.vin_ok = 1'b1;
        end else if (!f[FL_VIN_STOP]) begin
            s_d.vin_ok = 1'b0;
        end
        case (s_q.state)
            ST_FAULT: begin
                s_d.retry = 1'b0;
                if (!fault && f[FL_SS_CLR]) begin
                    ns = ST_CHARGE;
                end
            end
            ST_CHARGE: begin
                if (fault) begin
                    ns = ST_FAULT;
                end else if (f[FL_SS_OFF] && f[FL_SS_FB]) begin
                    ns = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fault) begin
                    ns = ST_FAULT;
                end else if (hard) begin
                    ns = ST_LATCH;
                end else if (ocp_if.reached || boot_if.reached) begin
                    ns = ST_HICCUP;
                    s_d.retry = 1'b1;
                end else if (f[FL_SS_REF]) begin
                    s_d.retry = 1'b0;
                end
            end
            ST_HICCUP: begin
                if (fault) begin
                    ns = ST_FAULT;
                end else if (f[FL_SS_HLOW]) begin
                    ns = ST_CHARGE;
                end
            end
            ST_LATCH: begin
                ns = ST_LATCH;
            end
            default: begin
                ns = ST_FAULT;
            end
        endcase
        s_d.state = ns;
        s_d.ss_src = (ns == ST_CHARGE) || (ns == ST_RUN);
        s_d.ss_fast = (ns == ST_FAULT) || (ns == ST_LATCH);
        s_d.ss_slow = (ns == ST_HICCUP);
        s_d.comp_pd = (ns != ST_RUN);
        s_d.pwm_en = (ns == ST_RUN);
        s_d.hs_off = (ns == ST_LATCH);
        s_d.tgt_ref = f[FL_SS_REF];
        s_d.half = s_d.retry;
        s_d.freq = rfh_freq(s_q.base,
                            f[FL_SS_REF] ? FB_W'(FB_FULL) : fb_s,
                            s_d.half);
        // Output-ok qualification and release delay
        if (f[FL_FB_OV] || f[FL_FB_UV] || f[FL_TSD] || !s_d.vin_ok ||
            !f[FL_FB_REG]) begin
            s_d.okcnt = '0;
            s_d.ok_oe = 1'b1;
        end else if (s_q.okcnt < OKW'(OK_DELAY)) begin
            s_d.okcnt = s_q.okcnt + 1'b1;
            s_d.ok_oe = 1'b1;
        end else begin
            s_d.ok_oe = 1'b0;
        end
        // APB slave
        s_d.pready = setup;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (setup) begin
            case (paddr)
                ADDR_CTRL: begin
                    s_d.prdata = 32'(s_q.ctrl_en);
                end
                ADDR_BASE: begin
                    s_d.prdata = 32'(s_q.base);
                end
                ADDR_STAT: begin
                    s_d.prdata = 32'(stat);
                end
                ADDR_CNT: begin
                    s_d.prdata = 32'(cnts);
                end
                default: begin
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && s_q.pready && pwrite) begin
            if (paddr == ADDR_CTRL) begin
                s_d.ctrl_en = pwdata[CTRL_EN_BIT];
            end else if (paddr == ADDR_BASE) begin
                s_d.base = pwdata[FREQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.state <= ST_FAULT;
            s_q.ss_fast <= 1'b1;
            s_q.comp_pd <= 1'b1;
            s_q.ok_oe <= 1'b1;
            s_q.ctrl_en <= CTRL_EN_RST;
            s_q.base <= BASE_FREQ_RST;
            s_q.freq <= FREQ_W'(FREQ_FLOOR_KHZ);
        end else begin
            s_q <= s_d;
        end
    end

    assign ok_ind_o = 1'b0;
    assign ok_ind_oe = s_q.ok_oe;
    assign ss_source_en = s_q.ss_src;
    assign ss_fast_dis = s_q.ss_fast;
    assign ss_slow_sink = s_q.ss_slow;
    assign comp_pull_down = s_q.comp_pd;
    assign pwm_enable = s_q.pwm_en;
    assign hs_force_off = s_q.hs_off;
    assign target_ref = s_q.tgt_ref;
    assign freq_khz = s_q.freq;
    assign freq_half = s_q.half;
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;

    // Checks
    property p_boot_miss;
        @(posedge clk_sys) disable iff (sys_rst)
        (run && !fault && !hard && f[FL_BOOT_MISS] && !f[FL_BOOT_SHORT] &&
         boot_if.count >= CNT_W'(BOOT_MISS_CYC)) |=> s_q.state == ST_HICCUP;
    endproperty
    a_boot_miss: assert property (p_boot_miss)
        else $error("boot missing did not enter hiccup");

    property p_boot_short;
        @(posedge clk_sys) disable iff (sys_rst)
        (run && !fault && !hard && f[FL_BOOT_SHORT] &&
         boot_if.count < CNT_W'(BOOT_SHORT_CYC)) |=> s_q.state != ST_HICCUP
         || $past(ocp_if.reached);
    endproperty
    a_boot_short: assert property (p_boot_short)
        else $error("boot short entered hiccup too early");

    property p_start_offset;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(s_q.pwm_en) |-> $past(f[FL_SS_OFF]) && $past(s_q.ss_src);
    endproperty
    a_start_offset: assert property (p_start_offset)
        else $error("switching began below soft-start offset");

    property p_prebias;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(s_q.pwm_en) |-> $past(f[FL_SS_FB]);
    endproperty
    a_prebias: assert property (p_prebias)
        else $error("switching began below pre-bias level");

    property p_floor;
        @(posedge clk_sys) disable iff (sys_rst)
        s_q.freq >= FREQ_W'(FREQ_FLOOR_KHZ);
    endproperty
    a_floor: assert property (p_floor)
        else $error("frequency below floor");

    property p_half;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_q.state == ST_HICCUP) |-> s_q.half;
    endproperty
    a_half: assert property (p_half)
        else $error("hiccup without halved frequency");

    property p_disable;
        @(posedge clk_sys) disable iff (sys_rst)
        (!f[FL_EN] && s_q.state != ST_LATCH) |=>
            s_q.ss_fast && s_q.state == ST_FAULT;
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable did not discharge soft-start");

    property p_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_q.state == ST_FAULT ##1 s_q.state == ST_CHARGE) |->
            $past(f[FL_SS_CLR]);
    endproperty
    a_clear: assert property (p_clear)
        else $error("fault latch cleared above clear level");

    property p_slow;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_q.state == ST_HICCUP) |-> s_q.ss_slow && !s_q.ss_fast &&
            s_q.comp_pd;
    endproperty
    a_slow: assert property (p_slow)
        else $error("hiccup without slow sink");

    property p_ok_delay;
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(s_q.ok_oe) |-> $past(s_q.okcnt) == OKW'(OK_DELAY);
    endproperty
    a_ok_delay: assert property (p_ok_delay)
        else $error("output-ok released before delay");

    property p_ok_drop;
        @(posedge clk_sys) disable iff (sys_rst)
        (f[FL_FB_OV] || f[FL_FB_UV] || f[FL_TSD]) |=> s_q.ok_oe;
    endproperty
    a_ok_drop: assert property (p_ok_drop)
        else $error("output-ok not pulled low at once");

    property p_latch;
        @(posedge clk_sys) disable iff (sys_rst)
        (s_q.state == ST_LATCH) |=> s_q.state == ST_LATCH && s_q.hs_off;
    endproperty
    a_latch: assert property (p_latch)
        else $error("hard short latch released");

    property p_ocp_low;
        @(posedge clk_sys) disable iff (sys_rst)
        (run && !fault && !hard && !f[FL_FB_MID] &&
         ocp_if.count >= CNT_W'(OCP_LIM_LOW)) |=> s_q.state == ST_HICCUP;
    endproperty
    a_ocp_low: assert property (p_ocp_low)
        else $error("pulse limit did not enter hiccup");
endmodule // rfh_sequencer
`default_nettype wire

// [rfh_stage_model.sv]
// Power stage model: PWM cycle clock, high-side pulses, output-ok pull-up
`timescale 1ns/1ps
`default_nettype none
module rfh_stage_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pwm_enable,
    input wire logic hs_force_off,
    input wire logic ok_ind_o,
    input wire logic ok_ind_oe,
    output logic pwm_tick,
    output logic hs_on,
    output logic ok_wire
);
    logic [2:0] phase_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !pwm_enable) begin
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end
    // Cycle clock stands still while switching is off
    assign pwm_tick = phase_q[2];
    assign hs_on = phase_q[2] && !hs_force_off;
    // Pull-up lifts the pin unless the device sinks it
    assign ok_wire = ok_ind_oe ? ok_ind_o : 1'b1;
endmodule // rfh_stage_model
`default_nettype wire

// [regulator_fault_hiccup_sequencer_bench.sv]
// Bench for the regulator fault and hiccup sequencer
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_hiccup_sequencer_bench;
import rfh_pkg::*;
localparam int P = 8;
logic clk_sys = 1'b0;
logic sys_rst = 1'b1;
logic [18:0] fl = '0;
logic [FB_W-1:0] fb = '0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [ADDR_W-1:0] paddr = '0;
logic [31:0] pwdata = '0;
logic [31:0] prdata, rd;
logic [FREQ_W-1:0] freq;
logic ok_o, oe, src, fdis, sink, cpd, pwm, hoff, tref, half;
logic pready, pslverr, tick, hs, okw;
int fail_count = 0;
int check_count = 0;
int cycles = 0;
int n;
int cf [4][3] = '{'{FL_I_BUCK, 30, 0}, '{FL_I_BB, 120, 1},
    '{FL_BOOT_MISS, 14, 0}, '{FL_BOOT_SHORT, 32, 0}};
wire logic [6:0] ob = {fdis, hoff, sink, pwm, src, oe, half};
always #25 clk_sys = ~clk_sys;
rfh_sequencer #(.OK_DELAY(20)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .flag_in({hs, tick, fl}), .fb_level(fb), .ok_ind_i(okw),
    .ok_ind_o(ok_o), .ok_ind_oe(oe), .ss_source_en(src),
    .ss_fast_dis(fdis), .ss_slow_sink(sink), .comp_pull_down(cpd),
    .pwm_enable(pwm), .hs_force_off(hoff), .target_ref(tref),
    .freq_khz(freq), .freq_half(half), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
rfh_stage_model stage (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .pwm_enable(pwm), .hs_force_off(hoff), .ok_ind_o(ok_o),
    .ok_ind_oe(oe), .pwm_tick(tick), .hs_on(hs), .ok_wire(okw));
task automatic finish_test();
    if (fail_count == 0 && check_count > 0) begin
        $display("Test passed");
    end else begin
        $display("Test failed");
    end
    $finish;
endtask
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
        fail_count++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d, input logic err);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
        @(posedge clk_sys);
        k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    check({31'h0, pready}, 32'h1);
    check({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic setf(input int i, input logic v);
    @(posedge clk_sys);
    fl[i] <= v;
endtask
task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
endtask
task automatic wait_for(input int b, input logic v, input int mx);
    n = 0;
    do begin
        @(negedge clk_sys);
        n++;
    end while (ob[b] !== v && n < mx);
    check({31'h0, ob[b]}, {31'h0, v});
endtask
always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
        fail_count++;
        finish_test();
    end
end
initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(1);
    check({31'h0, oe}, 32'h1);
    check({31'h0, fdis}, 32'h1);
    check({31'h0, ok_o}, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0, 1'b0);
    check(rd, 32'h1);
    apb(1'b0, ADDR_BASE, 32'h0, 1'b0);
    check(rd, 32'h190);
    apb(1'b0, 8'h10, 32'h0, 1'b1);
    check(rd, 32'h0);
    setf(FL_VIN_START, 1'b1);
    setf(FL_VIN_STOP, 1'b1);
    setf(FL_EN, 1'b1);
    setf(FL_SS_CLR, 1'b1);
    wait_for(2, 1'b1, 20);
    setf(FL_SS_CLR, 1'b0);
    setf(FL_SS_OFF, 1'b1);
    cyc(10);
    check({31'h0, pwm}, 32'h0);
    setf(FL_SS_FB, 1'b1);
    wait_for(3, 1'b1, 10);
    cyc(2);
    check({20'h0, freq}, 32'h64);
    apb(1'b1, ADDR_BASE, 32'h3E8, 1'b0);
    cyc(4);
    check({20'h0, freq}, 32'h78);
    @(posedge clk_sys);
    fb <= 8'hFF;
    cyc(5);
    check({20'h0, freq}, 32'h3E8);
    setf(FL_FB_REG, 1'b1);
    cyc(12);
    check({31'h0, oe}, 32'h1);
    wait_for(1, 1'b0, 40);
    for (int i = 0; i < 2; i++) begin
        setf(i ? FL_FB_UV : FL_FB_OV, 1'b1);
        cyc(4);
        check({31'h0, oe}, 32'h1);
        setf(i ? FL_FB_UV : FL_FB_OV, 1'b0);
        wait_for(1, 1'b0, 40);
    end
    setf(FL_I_BUCK, 1'b1);
    cyc(5 * P);
    setf(FL_I_BUCK, 1'b0);
    cyc(3 * P);
    apb(1'b0, ADDR_CNT, 32'h0, 1'b0);
    check(rd & 32'h7F, 32'h0);
    for (int i = 0; i < 4; i++) begin
        setf(FL_BB_MODE, cf[i][2] != 0);
        setf(FL_FB_MID, cf[i][2] != 0);
        setf(cf[i][0], 1'b1);
        wait_for(4, 1'b1, cf[i][1] * P + 100);
        check({31'h0, n >= (cf[i][1] - 2) * P && n <= cf[i][1] * P + 40},
            32'h1);
        check({31'h0, cpd}, 32'h1);
        check({31'h0, fdis}, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0, 1'b0);
        check(rd & 32'hFF, 32'hDB);
        setf(cf[i][0], 1'b0);
        setf(FL_SS_HLOW, 1'b1);
        wait_for(2, 1'b1, 10);
        check({31'h0, sink}, 32'h0);
        setf(FL_SS_HLOW, 1'b0);
        wait_for(3, 1'b1, 10);
        cyc(3);
        check({31'h0, half}, 32'h1);
        check({20'h0, freq}, 32'h1F4);
    end
    setf(FL_SS_REF, 1'b1);
    cyc(4);
    check({31'h0, tref}, 32'h1);
    check({20'h0, freq}, 32'h3E8);
    setf(FL_I_HARD, 1'b1);
    wait_for(5, 1'b1, 20);
    setf(FL_I_HARD, 1'b0);
    setf(FL_EN, 1'b0);
    cyc(6);
    check({31'h0, hoff}, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0, 1'b0);
    check(rd & 32'hFF, 32'hCC);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    setf(FL_EN, 1'b1);
    cyc(6);
    check({31'h0, src}, 32'h0);
    setf(FL_SS_CLR, 1'b1);
    wait_for(2, 1'b1, 10);
    apb(1'b1, ADDR_CTRL, 32'h0, 1'b0);
    wait_for(6, 1'b1, 10);
    apb(1'b1, ADDR_CTRL, 32'h1, 1'b0);
    wait_for(2, 1'b1, 10);
    setf(FL_EN, 1'b0);
    wait_for(6, 1'b1, 10);
    setf(FL_EN, 1'b1);
    wait_for(2, 1'b1, 10);
    setf(FL_VIN_START, 1'b0);
    cyc(6);
    check({31'h0, src}, 32'h1);
    setf(FL_VIN_STOP, 1'b0);
    wait_for(2, 1'b0, 10);
    check({31'h0, oe}, 32'h1);
    setf(FL_VIN_STOP, 1'b1);
    cyc(6);
    check({31'h0, src}, 32'h0);
    setf(FL_VIN_START, 1'b1);
    wait_for(2, 1'b1, 10);
    finish_test();
end
endmodule // regulator_fault_hiccup_sequencer_bench
`default_nettype wire
